// file: common/ddcc_pkg.sv
/*
  Package for the dual dispatch and completion control block: sizes, limits
  and the packed carriers for instructions, finish reports and branches.
  Assumes it is compiled before every file that names ddcc_pkg.
*/
package ddcc_pkg;

  // ****************************************************************
  // sizes and limits
  // ****************************************************************
  localparam int IQ_DEPTH = 6;
  localparam int RQ_DEPTH = 8;
  localparam int TOTAL_MAX = 12;
  localparam int INT_RENAMES = 6;
  localparam int FP_RENAMES = 6;
  localparam int VEC_RENAMES = 6;
  localparam int LOAD_UPDATE_DESTS = 2;
  localparam int DUAL_UPD_MAX = 2;
  localparam int NUM_UNITS = 8;
  localparam int NUM_FIN = 2;
  localparam int UNIT_W = 3;
  localparam int RQ_TAG_W = 3;
  localparam int RN_W = 3;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [UNIT_W-1:0] unit; // execution unit index
    logic int_dst; // writes one integer register
    logic load_update; // load that also writes back its address
    logic fp_dst;
    logic vec_dst;
    logic cr_upd; // updates the condition_register
    logic comp_ser; // completion-serialized
    logic refetch_ser; // refetch-serialized
    logic pair_class; // integer, load, touch, stream or vector class
  } ddcc_insn_t;

  typedef struct packed {
    logic valid;
    logic [RQ_TAG_W-1:0] tag;
    logic exc; // instruction raised an exception
  } ddcc_fin_t;

  typedef struct packed {
    logic valid;
    logic to_link; // branch to link_register
    logic to_count; // branch to count_register
    logic saves_link; // records a return address
    logic dec_and_cr; // decrements count_register and tests condition
    logic cond_on_cr; // conditioned on condition_register
  } ddcc_br_t;

endpackage : ddcc_pkg

// file: src/ddcc_rename_pool.sv
/*
  Free counter for one rename register file.
  Assumes the caller never allocates more than are free nor releases more
  than are held.
*/
`timescale 1ns/1ps
module ddcc_rename_pool #(
  parameter int N = 6,
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] alloc,
  input wire logic [W-1:0] release_cnt,
  output logic [W-1:0] free_cnt
);

  logic [W-1:0] next_free_cnt;

  // free count moves by releases minus allocations
  always_comb begin
    next_free_cnt = W'(free_cnt - alloc + release_cnt);
  end

  // every register free after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      free_cnt <= W'(N);
    end else begin
      free_cnt <= next_free_cnt;
    end
  end

endmodule : ddcc_rename_pool

// file: src/ddcc_core.sv
/*
  Dual dispatch and in-order dual completion control.
  Holds the issue_queue and retire_queue, rename free counts for the integer,
  float and vector files, and the branch resolution stall.
  Assumes fetch, the execution units and the branch_unit drive their inputs
  synchronously to ref_clk and report finishes only for dispatched tags.
*/
`timescale 1ns/1ps
module ddcc_core #(
  parameter int IQD = ddcc_pkg::IQ_DEPTH,
  parameter int RQD = ddcc_pkg::RQ_DEPTH,
  parameter int TMAX = ddcc_pkg::TOTAL_MAX,
  parameter int NU = ddcc_pkg::NUM_UNITS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] fetch_valid,
  input wire ddcc_pkg::ddcc_insn_t fetch_insn0,
  input wire ddcc_pkg::ddcc_insn_t fetch_insn1,
  output logic fetch_ready,
  input wire logic [NU-1:0] unit_busy,
  input wire logic pred_unresolved,
  input wire logic pred_resolved,
  input wire ddcc_pkg::ddcc_fin_t [ddcc_pkg::NUM_FIN-1:0] fin,
  input wire ddcc_pkg::ddcc_br_t br,
  input wire logic link_ready,
  input wire logic count_ready,
  input wire logic shadow_link_ready,
  input wire logic cr_cond_false,
  output logic [1:0] disp_valid,
  output ddcc_pkg::ddcc_insn_t disp_insn0,
  output ddcc_pkg::ddcc_insn_t disp_insn1,
  output logic [ddcc_pkg::RQ_TAG_W-1:0] disp_tag0,
  output logic [1:0] ret_valid,
  output logic [ddcc_pkg::RQ_TAG_W-1:0] ret_tag0,
  output logic head_exc,
  output logic br_stall,
  output logic br_go
);

  localparam int IAW = $clog2(IQD);
  localparam int RAW = ddcc_pkg::RQ_TAG_W;
  localparam int RN = ddcc_pkg::RN_W;
  localparam int TW = $clog2(IQD + RQD + 1); // holds both queues full

  // ****************************************************************
  // state
  // ****************************************************************
  ddcc_pkg::ddcc_insn_t iq_mem [IQD];
  ddcc_pkg::ddcc_insn_t next_iq_mem [IQD];
  logic [IAW-1:0] iq_rd, iq_wr, next_iq_rd, next_iq_wr;
  logic [IAW:0] iq_cnt, next_iq_cnt;
  ddcc_pkg::ddcc_insn_t rq_mem [RQD];
  ddcc_pkg::ddcc_insn_t next_rq_mem [RQD];
  logic [RQD-1:0] rq_fin, rq_exc, rq_spec, next_rq_fin, next_rq_exc, next_rq_spec;
  logic [RAW-1:0] rq_rd, rq_wr, next_rq_rd, next_rq_wr;
  logic [RAW:0] rq_cnt, next_rq_cnt;
  logic ser_busy, next_ser_busy;
  logic [RN-1:0] int_free, fp_free, vec_free;
  logic [RN-1:0] int_alloc, fp_alloc, vec_alloc, int_rel, fp_rel, vec_rel;
  logic [1:0] next_disp_valid, next_ret_valid;
  logic next_fetch_ready, next_head_exc, next_br_stall, next_br_go;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [IAW-1:0] iq_inc(input logic [IAW-1:0] p);
    iq_inc = (p == IAW'(IQD - 1)) ? '0 : IAW'(p + 1'b1);
  endfunction : iq_inc

  function automatic logic [RN-1:0] int_need(input ddcc_pkg::ddcc_insn_t i);
    if (i.load_update) begin
      int_need = RN'(ddcc_pkg::LOAD_UPDATE_DESTS);
    end else begin
      int_need = RN'(i.int_dst);
    end
  endfunction : int_need

  // ****************************************************************
  // dispatch and retire decisions
  // ****************************************************************
  ddcc_pkg::ddcc_insn_t i0, i1, r0, r1;
  logic [RN-1:0] n0, n1;
  logic ok0, ok1, rt0, rt1;
  logic [IAW-1:0] iq_rd1;
  logic [RAW-1:0] rq_rd1;

  // choose among the two oldest entries of each queue
  always_comb begin
    iq_rd1 = iq_inc(iq_rd);
    i0 = iq_mem[iq_rd];
    i1 = iq_mem[iq_rd1];
    n0 = int_need(i0);
    n1 = int_need(i1);
    rq_rd1 = RAW'(rq_rd + 1'b1);
    r0 = rq_mem[rq_rd];
    r1 = rq_mem[rq_rd1];
    // oldest entry
    ok0 = (iq_cnt != '0) && !unit_busy[i0.unit] && (int_free >= n0)
      && (fp_free >= RN'(i0.fp_dst)) && (vec_free >= RN'(i0.vec_dst))
      && (rq_cnt < (RAW+1)'(RQD)) && !ser_busy;
    // second entry sees what the oldest left
    ok1 = ok0 && (iq_cnt >= (IAW+1)'(2)) && !i0.comp_ser && !i0.refetch_ser
      && !unit_busy[i1.unit] && (i1.unit != i0.unit)
      && (int_free >= RN'(n0 + n1)) && (int_free >= n0)
      && (fp_free >= RN'(RN'(i0.fp_dst) + RN'(i1.fp_dst)))
      && (vec_free >= RN'(RN'(i0.vec_dst) + RN'(i1.vec_dst)))
      && ((rq_cnt + 1'b1) < (RAW+1)'(RQD));
    // oldest completion entry
    rt0 = (rq_cnt != '0) && rq_fin[rq_rd] && !rq_spec[rq_rd] && !rq_exc[rq_rd];
    // second completion entry
    rt1 = rt0 && (rq_cnt >= (RAW+1)'(2)) && rq_fin[rq_rd1] && !rq_spec[rq_rd1]
      && !rq_exc[rq_rd1]
      && r1.pair_class
      && (RN'(int_need(r0) + int_need(r1)) <= RN'(ddcc_pkg::DUAL_UPD_MAX))
      && (RN'(RN'(r0.fp_dst) + RN'(r1.fp_dst)) <= RN'(ddcc_pkg::DUAL_UPD_MAX))
      && (RN'(RN'(r0.vec_dst) + RN'(r1.vec_dst)) <= RN'(ddcc_pkg::DUAL_UPD_MAX))
      && (RN'(RN'(r0.cr_upd) + RN'(r1.cr_upd)) <= RN'(ddcc_pkg::DUAL_UPD_MAX));
    // renames claimed at dispatch and returned at retirement
    int_alloc = RN'((ok0 ? n0 : '0) + (ok1 ? n1 : '0));
    fp_alloc = RN'(RN'(ok0 & i0.fp_dst) + RN'(ok1 & i1.fp_dst));
    vec_alloc = RN'(RN'(ok0 & i0.vec_dst) + RN'(ok1 & i1.vec_dst));
    int_rel = RN'((rt0 ? int_need(r0) : '0) + (rt1 ? int_need(r1) : '0));
    fp_rel = RN'(RN'(rt0 & r0.fp_dst) + RN'(rt1 & r1.fp_dst));
    vec_rel = RN'(RN'(rt0 & r0.vec_dst) + RN'(rt1 & r1.vec_dst));
  end

  // ****************************************************************
  // issue_queue next state
  // ****************************************************************
  logic [1:0] push_n;
  always_comb begin
    next_iq_mem = iq_mem;
    next_iq_rd = iq_rd;
    next_iq_wr = iq_wr;
    push_n = '0;
    // fetch writes in program order when room was offered
    if (fetch_ready && fetch_valid[0]) begin
      next_iq_mem[next_iq_wr] = fetch_insn0;
      next_iq_wr = iq_inc(next_iq_wr);
      push_n = 2'h1;
      if (fetch_valid[1]) begin
        next_iq_mem[next_iq_wr] = fetch_insn1;
        next_iq_wr = iq_inc(next_iq_wr);
        push_n = 2'h2;
      end
    end
    if (ok0) begin
      next_iq_rd = ok1 ? iq_inc(iq_rd1) : iq_rd1;
    end
    next_iq_cnt = (IAW+1)'(iq_cnt + push_n - (IAW+1)'(ok0) - (IAW+1)'(ok1));
  end

  // ****************************************************************
  // retire_queue next state
  // ****************************************************************
  always_comb begin
    next_rq_mem = rq_mem;
    next_rq_fin = rq_fin;
    next_rq_exc = rq_exc;
    next_rq_spec = rq_spec;
    next_rq_wr = rq_wr;
    next_rq_rd = rq_rd;
    // resolution clears speculation on every held entry
    if (pred_resolved) begin
      next_rq_spec = '0;
    end
    // finish reports mark entries done
    for (int k = 0; k < ddcc_pkg::NUM_FIN; k++) begin
      if (fin[k].valid) begin
        next_rq_fin[fin[k].tag] = 1'b1;
        next_rq_exc[fin[k].tag] = fin[k].exc;
      end
    end
    // new entries are marked speculative while a branch is still unresolved
    if (ok0) begin
      next_rq_mem[rq_wr] = i0;
      next_rq_fin[rq_wr] = 1'b0;
      next_rq_exc[rq_wr] = 1'b0;
      next_rq_spec[rq_wr] = pred_unresolved;
      next_rq_wr = RAW'(rq_wr + 1'b1);
    end
    if (ok1) begin
      next_rq_mem[next_rq_wr] = i1;
      next_rq_fin[next_rq_wr] = 1'b0;
      next_rq_exc[next_rq_wr] = 1'b0;
      next_rq_spec[next_rq_wr] = pred_unresolved;
      next_rq_wr = RAW'(next_rq_wr + 1'b1);
    end
    if (rt0) begin
      next_rq_rd = rt1 ? RAW'(rq_rd + 2'h2) : rq_rd1;
    end
    next_rq_cnt = (RAW+1)'(rq_cnt + (RAW+1)'(ok0) + (RAW+1)'(ok1) - (RAW+1)'(rt0) - (RAW+1)'(rt1));
    // completion-serialized instruction blocks dispatch until it retires, set wins
    next_ser_busy = ser_busy;
    if ((rt0 && r0.comp_ser) || (rt1 && r1.comp_ser)) begin
      next_ser_busy = 1'b0;
    end
    if ((ok0 && i0.comp_ser) || (ok1 && i1.comp_ser)) begin
      next_ser_busy = 1'b1;
    end
  end

  // ****************************************************************
  // outputs next state
  // ****************************************************************
  logic [TW-1:0] next_total;
  always_comb begin
    next_total = TW'(next_iq_cnt) + TW'(next_rq_cnt);
    // room for two more in issue_queue and in the whole core
    next_fetch_ready = (next_iq_cnt <= (IAW+1)'(IQD - 2))
      && (next_total <= TW'(TMAX - 2));
    next_disp_valid = {ok1, ok0};
    next_ret_valid = {rt1, rt0};
    next_head_exc = (rq_cnt != '0) && rq_fin[rq_rd] && rq_exc[rq_rd];
    // branch resolution stalls on missing registers or, for a condition branch, an unresolved prediction
    next_br_stall = br.valid && ((br.to_link && !link_ready) || (br.to_count && !count_ready)
      || (br.saves_link && !shadow_link_ready))
      || br.valid && br.dec_and_cr && !(count_ready || cr_cond_false)
      || br.valid && br.cond_on_cr && pred_unresolved;
    next_br_go = br.valid && !next_br_stall;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < IQD; k++) begin
        iq_mem[k] <= '0;
      end
      for (int k = 0; k < RQD; k++) begin
        rq_mem[k] <= '0;
      end
      iq_rd <= '0;
      iq_wr <= '0;
      iq_cnt <= '0;
      rq_fin <= '0;
      rq_exc <= '0;
      rq_spec <= '0;
      rq_rd <= '0;
      rq_wr <= '0;
      rq_cnt <= '0;
      ser_busy <= 1'b0;
      fetch_ready <= 1'b0;
      disp_valid <= '0;
      disp_insn0 <= '0;
      disp_insn1 <= '0;
      disp_tag0 <= '0;
      ret_valid <= '0;
      ret_tag0 <= '0;
      head_exc <= 1'b0;
      br_stall <= 1'b0;
      br_go <= 1'b0;
    end else begin
      iq_mem <= next_iq_mem;
      rq_mem <= next_rq_mem;
      iq_rd <= next_iq_rd;
      iq_wr <= next_iq_wr;
      iq_cnt <= next_iq_cnt;
      rq_fin <= next_rq_fin;
      rq_exc <= next_rq_exc;
      rq_spec <= next_rq_spec;
      rq_rd <= next_rq_rd;
      rq_wr <= next_rq_wr;
      rq_cnt <= next_rq_cnt;
      ser_busy <= next_ser_busy;
      fetch_ready <= next_fetch_ready;
      disp_valid <= next_disp_valid;
      disp_insn0 <= i0;
      disp_insn1 <= i1;
      disp_tag0 <= rq_wr;
      ret_valid <= next_ret_valid;
      ret_tag0 <= rq_rd;
      head_exc <= next_head_exc;
      br_stall <= next_br_stall;
      br_go <= next_br_go;
    end
  end

  // ****************************************************************
  // rename pools
  // ****************************************************************
  ddcc_rename_pool #(.N(ddcc_pkg::INT_RENAMES), .W(RN)) u_int_pool (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .alloc(int_alloc),
    .release_cnt(int_rel),
    .free_cnt(int_free)
  );

  ddcc_rename_pool #(.N(ddcc_pkg::FP_RENAMES), .W(RN)) u_fp_pool (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .alloc(fp_alloc),
    .release_cnt(fp_rel),
    .free_cnt(fp_free)
  );

  ddcc_rename_pool #(.N(ddcc_pkg::VEC_RENAMES), .W(RN)) u_vec_pool (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .alloc(vec_alloc),
    .release_cnt(vec_rel),
    .free_cnt(vec_free)
  );

endmodule : ddcc_core

// file: dv/ddcc_core_asserts.sv
/*
  Checker for ddcc_core: dispatch pairing, unit use, retire pairing, branch stall.
  Assumes it is bound to ddcc_core and sees only its ports.
*/
`timescale 1ns/1ps
module ddcc_core_checker #(
  parameter int NU = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NU-1:0] unit_busy,
  input wire logic pred_unresolved,
  input wire ddcc_pkg::ddcc_br_t br,
  input wire logic link_ready,
  input wire logic count_ready,
  input wire logic cr_cond_false,
  input wire logic [1:0] disp_valid,
  input wire ddcc_pkg::ddcc_insn_t disp_insn0,
  input wire ddcc_pkg::ddcc_insn_t disp_insn1,
  input wire logic [1:0] ret_valid,
  input wire logic br_stall,
  input wire logic br_go
);
  // ********
  // helpers and assertions
  // ********
  logic [NU-1:0] prev_busy;
  logic [NU-1:0] next_prev_busy;
  logic [4:0] inflight;
  logic [4:0] next_inflight;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // busy map of the deciding cycle, dispatched minus retired
  always_comb begin
    next_prev_busy = unit_busy;
    next_inflight = inflight + 5'(disp_valid[0]) + 5'(disp_valid[1]) - 5'(ret_valid[0]) - 5'(ret_valid[1]);
  end
  // register the helpers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_busy <= '0;
      inflight <= 5'h00;
    end else begin
      prev_busy <= next_prev_busy;
      inflight <= next_inflight;
    end
  end
  a_pair_disp: assert property (disp_valid[1] |-> disp_valid[0])
    else $error("second dispatched without oldest");
  a_second_ser: assert property (disp_valid[1] |-> !disp_insn0.comp_ser && !disp_insn0.refetch_ser)
    else $error("second dispatched behind serializer");
  a_unit_free: assert property (disp_valid[0] |-> !prev_busy[disp_insn0.unit])
    else $error("oldest dispatched to busy unit");
  a_second_unit: assert property (disp_valid[1] |->
    disp_insn1.unit != disp_insn0.unit && !prev_busy[disp_insn1.unit])
    else $error("second dispatched to taken unit");
  a_pair_retire: assert property (ret_valid[1] |-> ret_valid[0])
    else $error("second retired without oldest");
  a_link_stall: assert property (br.valid && br.to_link && !link_ready |=> br_stall && !br_go)
    else $error("link branch not stalled");
  a_count_stall: assert property (br.valid && br.to_count && !count_ready |=> br_stall && !br_go)
    else $error("count branch not stalled");
  a_dec_stall: assert property (br.valid && br.dec_and_cr && !count_ready && !cr_cond_false |=> br_stall)
    else $error("decrement branch not stalled");
  a_cond_stall: assert property (br.valid && br.cond_on_cr && pred_unresolved |=> br_stall && !br_go)
    else $error("condition branch ran past prediction");
  a_inflight_max: assert property (inflight <= 5'h08)
    else $error("more than eight in flight");
  a_reset_quiet: assert property ($rose(rst_n) |-> disp_valid == 2'h0 && ret_valid == 2'h0)
    else $error("activity right after reset");
endmodule : ddcc_core_checker

// file: dv/ddcc_exec_model.sv
/*
  Execution unit model: finishes dispatched retire_queue tags in order.
  Assumes disp_valid and disp_tag0 from ddcc_core; hold and exc come from the bench.
*/
`timescale 1ns/1ps
module ddcc_exec_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] disp_valid,
  input wire logic [ddcc_pkg::RQ_TAG_W-1:0] disp_tag0,
  input wire logic hold,
  input wire logic exc,
  output ddcc_pkg::ddcc_fin_t [ddcc_pkg::NUM_FIN-1:0] fin
);
  // ********
  // finish queue
  // ********
  logic [ddcc_pkg::RQ_TAG_W-1:0] pend [$];
  ddcc_pkg::ddcc_fin_t [ddcc_pkg::NUM_FIN-1:0] nf;
  // queue dispatched tags, finish up to two a cycle unless held
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend.delete();
      fin <= '0;
    end else begin
      if (disp_valid[0]) pend.push_back(disp_tag0);
      if (disp_valid[1]) pend.push_back(disp_tag0 + 3'h1);
      for (int i = 0; i < 2; i++) begin
        nf[i] = '{valid: 1'b0, tag: ~fin[i].tag, exc: ~fin[i].exc}; // idle slot inverts the tag and exc of last cycle
        if (!hold && pend.size() > 0) nf[i] = '{valid: 1'b1, tag: pend.pop_front(), exc: exc};
      end
      fin <= #1 nf;
    end
  end
endmodule : ddcc_exec_model

// file: dv/dual_dispatch_completion_control_test.sv
/*
  Self-checking bench for ddcc_core with the execution unit model.
  Assumes ddcc_pkg, ddcc_core and the checker are compiled first.
*/
`timescale 1ns/1ps
module dual_dispatch_completion_control_test;
  // ********
  // signals, design and partner
  // ********
  localparam logic [11:0] br_rows [8] = '{12'hC1D, 12'hC3C, 12'hA2D, 12'h935, 12'h8A9, 12'h8AC, 12'h87F, 12'h87C};
  logic ref_clk, rst_n, fetch_ready, pred_unresolved, pred_resolved, link_ready, count_ready;
  logic shadow_link_ready, cr_cond_false, head_exc, br_stall, br_go, hold, exc;
  logic [1:0] fetch_valid, disp_valid, ret_valid;
  logic [2:0] disp_tag0, ret_tag0, last_ret;
  logic [7:0] unit_busy;
  ddcc_pkg::ddcc_insn_t fetch_insn0, fetch_insn1, disp_insn0, disp_insn1;
  ddcc_pkg::ddcc_fin_t [ddcc_pkg::NUM_FIN-1:0] fin;
  ddcc_pkg::ddcc_br_t br;
  int errors, num_checks, nd, nr, dual_d, dual_r;

  ddcc_core ddcc_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_insn0(fetch_insn0), .fetch_insn1(fetch_insn1), .fetch_ready(fetch_ready), .unit_busy(unit_busy),
    .pred_unresolved(pred_unresolved), .pred_resolved(pred_resolved), .fin(fin), .br(br),
    .link_ready(link_ready), .count_ready(count_ready), .shadow_link_ready(shadow_link_ready),
    .cr_cond_false(cr_cond_false), .disp_valid(disp_valid), .disp_insn0(disp_insn0),
    .disp_insn1(disp_insn1), .disp_tag0(disp_tag0), .ret_valid(ret_valid), .ret_tag0(ret_tag0),
    .head_exc(head_exc), .br_stall(br_stall), .br_go(br_go));
  ddcc_exec_model ddcc_exec_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .disp_valid(disp_valid),
    .disp_tag0(disp_tag0), .hold(hold), .exc(exc), .fin(fin));

  // core clock, 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // count dispatches and retirements seen at the ports
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {nd, nr, dual_d, dual_r} = '0;
      last_ret = 3'h0;
    end else begin
      if (ret_valid[0] === 1'b1) last_ret = ret_tag0; // tag of the latest oldest retired
      nd += disp_valid[0] + disp_valid[1];
      nr += ret_valid[0] + ret_valid[1];
      dual_d += (disp_valid === 2'h3);
      dual_r += (ret_valid === 2'h3);
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic run(input int n);
    fetch_valid = 2'h0;
    repeat (n) tick();
  endtask : run
  function automatic ddcc_pkg::ddcc_insn_t ins(input logic [2:0] u, input logic [7:0] f);
    return {u, f};
  endfunction : ins
  task automatic reset_dut();
    rst_n = 1'b0;
    {fetch_valid, fetch_insn0, fetch_insn1, unit_busy, pred_unresolved, pred_resolved, br, hold, exc} = '0;
    {link_ready, count_ready, shadow_link_ready, cr_cond_false} = 4'hE;
    repeat (8) tick();
    rst_n = 1'b1;
    tick();
  endtask : reset_dut
  // hold the offer until an edge samples fetch_ready high
  task automatic offer(input ddcc_pkg::ddcc_insn_t a, input ddcc_pkg::ddcc_insn_t b, input logic [1:0] v);
    logic ok;
    int n;
    fetch_insn0 = a;
    fetch_insn1 = b;
    fetch_valid = v;
    n = 0;
    do begin
      ok = fetch_ready;
      tick();
      n++;
    end while (!ok && n < 100);
    if (!ok) begin
      errors++;
      stop_test();
    end
  endtask : offer

  // ********
  // scenarios
  // ********
  task automatic dual_pair();
    reset_dut();
    check("disp_valid", disp_valid, 8'h00);
    check("fetch_ready", fetch_ready, 8'h01);
    offer(ins(0, 8'h81), ins(1, 8'h81), 2'h3);
    run(12);
    check("dual dispatch", 8'(dual_d), 8'h01);
    check("dual retire", 8'(dual_r), 8'h01);
    check("retired", 8'(nr), 8'h02);
  endtask : dual_pair
  task automatic unit_rules();
    reset_dut();
    unit_busy = 8'h01;
    offer(ins(0, 8'h81), ins(1, 8'h81), 2'h3);
    run(6);
    check("busy unit", 8'(nd), 8'h00);
    unit_busy = 8'h00;
    run(10);
    offer(ins(2, 8'h81), ins(2, 8'h81), 2'h3);
    run(12);
    check("same unit", 8'(nd), 8'h04);
    check("same unit dual", 8'(dual_d), 8'h01);
  endtask : unit_rules
  task automatic serial_rule();
    reset_dut();
    offer(ins(0, 8'h85), ins(1, 8'h81), 2'h3);
    run(12);
    offer(ins(0, 8'h83), ins(1, 8'h81), 2'h3);
    run(12);
    check("ser dual", 8'(dual_d), 8'h00);
    check("ser count", 8'(nd), 8'h04);
  endtask : serial_rule
  task automatic rename_rules();
    reset_dut();
    hold = 1'b1;
    offer(ins(0, 8'hC1), ins(1, 8'hC1), 2'h3);
    offer(ins(2, 8'hC1), ins(3, 8'h81), 2'h3);
    run(10);
    check("int renames", 8'(nd), 8'h03);
    hold = 1'b0;
    run(20);
    check("int released", 8'(nd), 8'h04);
    hold = 1'b1;
    for (int i = 0; i < 4; i++) offer(ins(3'(2 * i), 8'h30), ins(3'(2 * i + 1), 8'h30), 2'h3);
    run(10);
    check("fp renames", 8'(nd), 8'h0A);
    hold = 1'b0;
    run(30);
    check("fp released", 8'(nd), 8'h0C);
  endtask : rename_rules
  task automatic retire_rules();
    reset_dut();
    offer(ins(0, 8'h81), ins(1, 8'h80), 2'h3);
    run(10);
    check("class dual", 8'(dual_r), 8'h00);
    offer(ins(0, 8'hC1), ins(1, 8'h81), 2'h3);
    run(10);
    check("update dual", 8'(dual_r), 8'h00);
    check("retired", 8'(nr), 8'h04);
    check("ret_tag0", 8'(last_ret), 8'h03);
  endtask : retire_rules
  task automatic inflight_rule();
    reset_dut();
    hold = 1'b1;
    for (int i = 0; i < 6; i++) offer(ins(3'(2 * i), 8'h01), ins(3'(2 * i + 1), 8'h01), 2'h3);
    run(10);
    check("in flight", 8'(nd), 8'h08);
    check("full", fetch_ready, 8'h00);
    hold = 1'b0;
    run(30);
    check("drained", 8'(nd), 8'h0C);
  endtask : inflight_rule
  task automatic spec_exc();
    reset_dut();
    pred_unresolved = 1'b1;
    offer(ins(0, 8'h81), ins(1, 8'h81), 2'h1);
    run(8);
    check("spec held", 8'(nr), 8'h00);
    pred_unresolved = 1'b0;
    pred_resolved = 1'b1;
    tick();
    pred_resolved = 1'b0;
    run(8);
    check("spec freed", 8'(nr), 8'h01);
    exc = 1'b1;
    offer(ins(1, 8'h81), ins(1, 8'h81), 2'h1);
    run(8);
    check("head_exc", head_exc, 8'h01);
    check("exc held", 8'(nr), 8'h01);
  endtask : spec_exc
  task automatic branch_rules();
    reset_dut();
    for (int i = 0; i < 8; i++) begin
      {br, link_ready, count_ready, shadow_link_ready, cr_cond_false, pred_unresolved} = br_rows[i][11:1];
      tick();
      check("br_stall", br_stall, br_rows[i][0]);
      check("br_go", br_go, !br_rows[i][0]);
    end
  endtask : branch_rules

  // main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    dual_pair();
    unit_rules();
    serial_rule();
    rename_rules();
    retire_rules();
    inflight_rule();
    spec_exc();
    branch_rules();
    stop_test();
  end
endmodule : dual_dispatch_completion_control_test

bind ddcc_core ddcc_core_checker #(.NU(NU)) ddcc_core_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .unit_busy(unit_busy), .pred_unresolved(pred_unresolved), .br(br), .link_ready(link_ready),
  .count_ready(count_ready), .cr_cond_false(cr_cond_false), .disp_valid(disp_valid),
  .disp_insn0(disp_insn0), .disp_insn1(disp_insn1), .ret_valid(ret_valid), .br_stall(br_stall), .br_go(br_go));
